// File: common/pxbar_pkg.sv
// package: register map, field positions and carrier types of the pin crossbar
package pxbar_pkg;

    // =========================================================
    // register map on the special-function bus
    // =========================================================
    localparam logic [7:0] PXBAR_ADDR_ROUTE_A = 8'he1;  // peripheral_route_enable_a
    localparam logic [7:0] PXBAR_ADDR_CTRL_B  = 8'he2;  // crossbar_control_b
    localparam logic [7:0] PXBAR_RST_ROUTE_A  = 8'h00;
    localparam logic [7:0] PXBAR_RST_CTRL_B   = 8'h00;
    localparam logic [7:0] PXBAR_MASK_ROUTE_A = 8'h3f;  // bits 7:6 read as zero
    localparam logic [7:0] PXBAR_MASK_CTRL_B  = 8'hfb;  // bit 2 reserved, reads zero

    // =========================================================
    // field positions, route register a
    // =========================================================
    localparam int PXBAR_A_UART  = 0;
    localparam int PXBAR_A_SPI   = 1;
    localparam int PXBAR_A_LIN   = 2;
    localparam int PXBAR_A_SYSCK = 3;
    localparam int PXBAR_A_CMPS  = 4;
    localparam int PXBAR_A_CMPA  = 5;

    // =========================================================
    // field positions, control register b
    // =========================================================
    localparam int PXBAR_B_CAP_LO = 0;
    localparam int PXBAR_B_ECI    = 3;
    localparam int PXBAR_B_TMRA   = 4;
    localparam int PXBAR_B_TMRB   = 5;
    localparam int PXBAR_B_ENABLE = 6;
    localparam int PXBAR_B_PUDIS  = 7;

    // =========================================================
    // pin and resource geometry
    // =========================================================
    localparam int PXBAR_NPINS   = 16;
    localparam int PXBAR_NSLOTS  = 15;          // resources in priority order, uart excluded
    localparam int PXBAR_PIN_W   = 4;
    localparam logic [3:0] PXBAR_UART_TX_PIN_A = 4'h4;  // later variant
    localparam logic [3:0] PXBAR_UART_RX_PIN_A = 4'h5;
    localparam logic [3:0] PXBAR_UART_TX_PIN_B = 4'h3;  // alternate variant
    localparam logic [3:0] PXBAR_UART_RX_PIN_B = 4'h4;
    localparam logic [1:0] PXBAR_NSS_4WIRE_LO  = 2'h2;  // select field 1x routes nss

    // slot order after the uart (priority order, low index wins)
    localparam int PXBAR_S_SCK  = 0;
    localparam int PXBAR_S_MISO = 1;
    localparam int PXBAR_S_MOSI = 2;
    localparam int PXBAR_S_NSS  = 3;
    localparam int PXBAR_S_SDA  = 4;
    localparam int PXBAR_S_SCL  = 5;
    localparam int PXBAR_S_CMPS = 6;
    localparam int PXBAR_S_CMPA = 7;
    localparam int PXBAR_S_SYSK = 8;
    localparam int PXBAR_S_CEXA = 9;
    localparam int PXBAR_S_CEXB = 10;
    localparam int PXBAR_S_CEXC = 11;
    localparam int PXBAR_S_ECI  = 12;
    localparam int PXBAR_S_TMRA = 13;
    localparam int PXBAR_S_TMRB = 14;

    // per-pin signals of one peripheral slot
    typedef struct packed {
        logic out;   // value the peripheral drives
        logic oe;    // peripheral wants to drive
    } pxbar_sig_t;

    // per-pin controls from the port mode registers
    typedef struct packed {
        logic [PXBAR_NPINS-1:0] latch;    // port output latch
        logic [PXBAR_NPINS-1:0] digital;  // pin_input_kind_bits, 1 = digital
        logic [PXBAR_NPINS-1:0] pushpull; // pin_driver_type_bits, 1 = push-pull
        logic [PXBAR_NPINS-1:0] skip;     // pin_skip_bits
    } pxbar_portcfg_t;

    // register state
    typedef struct packed {
        logic [7:0] route_a;
        logic [7:0] ctrl_b;
        logic [7:0] rdata;
    } pxbar_state_t;

endpackage

// File: rtl/pxbar_alloc.sv
// priority allocator: assigns each requested slot to the lowest free pin
`timescale 1ns/1ps
module pxbar_alloc #(
    parameter int NPINS  = 16,
    parameter int NSLOTS = 15,
    parameter int PIN_W  = 4
) (
    input  wire logic [NSLOTS-1:0]       i_req,      // slot requests in priority order
    input  wire logic [NPINS-1:0]        i_taken,    // skipped or fixed pins
    output logic      [NSLOTS-1:0]       o_placed,   // slot found a pin
    output logic      [NSLOTS*PIN_W-1:0] o_pin       // chosen pin per slot
);

    // =========================================================
    // sequential search unrolled by a generate chain
    // =========================================================
    logic [NPINS-1:0] used [NSLOTS+1];  // occupancy before each slot

    assign used[0] = i_taken;

    genvar s;
    generate
        for (s = 0; s < NSLOTS; s++)
        begin : g_slot
            logic             found;
            logic [PIN_W-1:0] idx;
            // lowest pin not yet used or skipped
            always_comb
            begin
                found = 1'b0;
                idx   = '0;
                for (int p = 0; p < NPINS; p++)
                begin
                    if (!found && !used[s][p])
                    begin
                        found = 1'b1;
                        idx   = PIN_W'(p);
                    end
                end
            end
            assign o_placed[s]                = i_req[s] && found;
            assign o_pin[s*PIN_W +: PIN_W]    = idx;
            // later slots pass over this pin once claimed
            assign used[s+1] = (i_req[s] && found) ? (used[s] | (NPINS'(1) << idx)) : used[s];
        end
    endgenerate

endmodule

// File: rtl/pxbar_top.sv
// priority crossbar pin router: routing registers and per-pin output muxing
`timescale 1ns/1ps
//
// Overview of operation
// - resources evaluated in fixed order, uart first
// - each resource after the uart gets lowest free pin
// - uart lines fixed to variant pins
// - assigned pins passed over for later resources
// - skipped pins treated as already assigned
// - smbus and uart each claim both pins
// - leftover pins remain general-purpose port pins
// - spi takes three pins, four in 4-wire
// - enable clear: all inputs, drivers off
// - pin state always readable at port data on digital pins, analog reads zero
// - weak pullup only open-drain, not driving low
// - analog pin: no pullup, driver, receiver
// - input kind 1 digital, reset all digital
// - driver type follows mode bit, except smbus pins forced open-drain
// - route register a bit assignment
// - control register b timer, eci bits
// - capture field routes zero to three channels
// - open-drain latch one is high impedance
// - smbus pins always open-drain
module pxbar_top #(
    parameter bit UART_ALT_PINS = 1'b0  // 1 selects tx/rx on the lower pin pair
) (
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_sys_rst,
    // special-function bus
    input  wire logic [7:0]                     i_sfr_addr,
    input  wire logic [7:0]                     i_sfr_wdata,
    input  wire logic                           i_sfr_wr,
    input  wire logic                           i_sfr_rd,
    output logic      [7:0]                     o_sfr_rdata,
    output logic                                o_sfr_hit,
    // port configuration from the port register block
    input  wire pxbar_pkg::pxbar_portcfg_t      i_port_cfg,
    input  wire logic [1:0]                     i_spi_select_mode_field,
    // peripheral outputs
    input  wire pxbar_pkg::pxbar_sig_t          i_uart_tx,
    input  wire pxbar_pkg::pxbar_sig_t          i_spi_sck,
    input  wire pxbar_pkg::pxbar_sig_t          i_spi_miso,
    input  wire pxbar_pkg::pxbar_sig_t          i_spi_mosi,
    input  wire pxbar_pkg::pxbar_sig_t          i_spi_nss,
    input  wire pxbar_pkg::pxbar_sig_t          i_smb_sda,
    input  wire pxbar_pkg::pxbar_sig_t          i_smb_scl,
    input  wire logic                           i_comparator_output,
    input  wire logic                           i_comparator_output_async,
    input  wire logic                           i_sysclk_inv,
    input  wire pxbar_pkg::pxbar_sig_t          i_cex_a,
    input  wire pxbar_pkg::pxbar_sig_t          i_cex_b,
    input  wire pxbar_pkg::pxbar_sig_t          i_cex_c,
    // pins
    input  wire logic [15:0]                    i_pin_in,
    output logic      [15:0]                    o_pin_out,
    output logic      [15:0]                    o_pin_oe,
    output logic      [15:0]                    o_pin_pullup,
    output logic      [15:0]                    o_pin_rx_en,
    // port data read path and peripheral inputs
    output logic      [15:0]                    o_port_read,
    output logic                                o_uart_receive_line,
    output logic                                o_spi_sck_in,
    output logic                                o_spi_miso_in,
    output logic                                o_spi_mosi_in,
    output logic                                o_spi_nss_in,
    output logic                                o_smb_sda_in,
    output logic                                o_smb_scl_in,
    output logic                                o_capture_a_in,
    output logic                                o_capture_b_in,
    output logic                                o_capture_c_in,
    output logic                                o_counter_array_clock_in,
    output logic                                o_timer_a_in,
    output logic                                o_timer_b_in
);

    // geometry from the package so all files agree
    localparam int NP = pxbar_pkg::PXBAR_NPINS;
    localparam int NS = pxbar_pkg::PXBAR_NSLOTS;
    localparam int PW = pxbar_pkg::PXBAR_PIN_W;

    // =========================================================
    // state
    // =========================================================
    pxbar_pkg::pxbar_state_t st_q;   // registered state
    pxbar_pkg::pxbar_state_t st_d;   // next state

    // field views
    logic       router_enable;       // crossbar enable
    logic       pullup_disable;      // global weak pullup off
    logic [1:0] capture_channel_route_count;
    logic       spi_four_wire;

    // plain wires, no extra flops
    assign router_enable               = st_q.ctrl_b[pxbar_pkg::PXBAR_B_ENABLE];
    assign pullup_disable              = st_q.ctrl_b[pxbar_pkg::PXBAR_B_PUDIS];
    assign capture_channel_route_count = st_q.ctrl_b[pxbar_pkg::PXBAR_B_CAP_LO +: 2];
    // 4-wire modes have the upper select bit set
    assign spi_four_wire = (i_spi_select_mode_field & pxbar_pkg::PXBAR_NSS_4WIRE_LO) != 2'h0;

    // =========================================================
    // register file
    // =========================================================
    // one process builds the next state, reads return the registered value next cycle
    always_comb
    begin
        st_d = st_q;
        if (i_sfr_wr && i_sfr_addr == pxbar_pkg::PXBAR_ADDR_ROUTE_A)
        begin
            // reserved high bits forced to zero so they read 00b
            st_d.route_a = i_sfr_wdata & pxbar_pkg::PXBAR_MASK_ROUTE_A;
        end
        else if (i_sfr_wr && i_sfr_addr == pxbar_pkg::PXBAR_ADDR_CTRL_B)
        begin
            // reserved bit stored as zero
            st_d.ctrl_b = i_sfr_wdata & pxbar_pkg::PXBAR_MASK_CTRL_B;
        end
        // read data
        if (i_sfr_rd && i_sfr_addr == pxbar_pkg::PXBAR_ADDR_ROUTE_A)
        begin
            st_d.rdata = st_q.route_a;
        end
        else if (i_sfr_rd && i_sfr_addr == pxbar_pkg::PXBAR_ADDR_CTRL_B)
        begin
            st_d.rdata = st_q.ctrl_b;
        end
        else
        begin
            st_d.rdata = 8'h00;   // unmapped reads as zero
        end
    end

    // synchronous reset, both registers clear
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            st_q.route_a <= pxbar_pkg::PXBAR_RST_ROUTE_A;
            st_q.ctrl_b  <= pxbar_pkg::PXBAR_RST_CTRL_B;
            st_q.rdata   <= 8'h00;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // flopped data keeps decode glitches off the bus
    assign o_sfr_rdata = st_q.rdata;
    // combinational decode hit for the bus mux
    assign o_sfr_hit = (i_sfr_addr == pxbar_pkg::PXBAR_ADDR_ROUTE_A)
                    || (i_sfr_addr == pxbar_pkg::PXBAR_ADDR_CTRL_B);

    // =========================================================
    // uart fixed pins and slot requests
    // =========================================================
    logic          uart_on;     // uart claims tx and rx together
    logic [PW-1:0] uart_tx_pin;
    logic [PW-1:0] uart_rx_pin;
    logic [NP-1:0] fixed_mask;  // pins taken before the priority search
    logic [NS-1:0] req;         // slot requests after uart

    assign uart_on     = st_q.route_a[pxbar_pkg::PXBAR_A_UART];
    // uart bypasses the lowest-free search for bootloading
    assign uart_tx_pin = UART_ALT_PINS ? pxbar_pkg::PXBAR_UART_TX_PIN_B
                                       : pxbar_pkg::PXBAR_UART_TX_PIN_A;
    assign uart_rx_pin = UART_ALT_PINS ? pxbar_pkg::PXBAR_UART_RX_PIN_B
                                       : pxbar_pkg::PXBAR_UART_RX_PIN_A;
    // both pins claimed as a pair; skipped pins count as assigned
    assign fixed_mask = i_port_cfg.skip
                      | (uart_on ? ((NP'(1) << uart_tx_pin) | (NP'(1) << uart_rx_pin))
                                 : NP'(0));

    // request vector in priority order, one entry per pin function
    always_comb
    begin
        req = '0;
        req[pxbar_pkg::PXBAR_S_SCK]  = st_q.route_a[pxbar_pkg::PXBAR_A_SPI];
        req[pxbar_pkg::PXBAR_S_MISO] = st_q.route_a[pxbar_pkg::PXBAR_A_SPI];
        req[pxbar_pkg::PXBAR_S_MOSI] = st_q.route_a[pxbar_pkg::PXBAR_A_SPI];
        req[pxbar_pkg::PXBAR_S_NSS]  = st_q.route_a[pxbar_pkg::PXBAR_A_SPI] && spi_four_wire;
        // lin enable carries the two-wire bus pins as a pair
        req[pxbar_pkg::PXBAR_S_SDA]  = st_q.route_a[pxbar_pkg::PXBAR_A_LIN];
        req[pxbar_pkg::PXBAR_S_SCL]  = st_q.route_a[pxbar_pkg::PXBAR_A_LIN];
        req[pxbar_pkg::PXBAR_S_CMPS] = st_q.route_a[pxbar_pkg::PXBAR_A_CMPS];
        req[pxbar_pkg::PXBAR_S_CMPA] = st_q.route_a[pxbar_pkg::PXBAR_A_CMPA];
        req[pxbar_pkg::PXBAR_S_SYSK] = st_q.route_a[pxbar_pkg::PXBAR_A_SYSCK];
        req[pxbar_pkg::PXBAR_S_CEXA] = capture_channel_route_count != 2'h0;
        req[pxbar_pkg::PXBAR_S_CEXB] = capture_channel_route_count[1];
        req[pxbar_pkg::PXBAR_S_CEXC] = capture_channel_route_count == 2'h3;
        req[pxbar_pkg::PXBAR_S_ECI]  = st_q.ctrl_b[pxbar_pkg::PXBAR_B_ECI];
        req[pxbar_pkg::PXBAR_S_TMRA] = st_q.ctrl_b[pxbar_pkg::PXBAR_B_TMRA];
        req[pxbar_pkg::PXBAR_S_TMRB] = st_q.ctrl_b[pxbar_pkg::PXBAR_B_TMRB];
    end

    // =========================================================
    // priority search
    // =========================================================
    logic [NS-1:0]    placed;   // slot got a pin
    logic [NS*PW-1:0] slot_pin; // pin per slot

    // lowest free pin per slot, claimed pins passed over
    pxbar_alloc #(
        .NPINS  (NP),
        .NSLOTS (NS),
        .PIN_W  (PW)
    ) u_alloc (
        .i_req    (req),
        .i_taken  (fixed_mask),
        .o_placed (placed),
        .o_pin    (slot_pin)
    );

    // slot drive sources
    pxbar_pkg::pxbar_sig_t slot_sig [NS];

    always_comb
    begin
        for (int k = 0; k < NS; k++)
        begin
            slot_sig[k] = '0;   // input-only slots never drive
        end
        slot_sig[pxbar_pkg::PXBAR_S_SCK]  = i_spi_sck;
        slot_sig[pxbar_pkg::PXBAR_S_MISO] = i_spi_miso;
        slot_sig[pxbar_pkg::PXBAR_S_MOSI] = i_spi_mosi;
        slot_sig[pxbar_pkg::PXBAR_S_NSS]  = i_spi_nss;
        slot_sig[pxbar_pkg::PXBAR_S_SDA]  = i_smb_sda;
        slot_sig[pxbar_pkg::PXBAR_S_SCL]  = i_smb_scl;
        slot_sig[pxbar_pkg::PXBAR_S_CMPS] = '{out: i_comparator_output, oe: 1'b1};
        slot_sig[pxbar_pkg::PXBAR_S_CMPA] = '{out: i_comparator_output_async, oe: 1'b1};
        slot_sig[pxbar_pkg::PXBAR_S_SYSK] = '{out: i_sysclk_inv, oe: 1'b1};
        slot_sig[pxbar_pkg::PXBAR_S_CEXA] = i_cex_a;
        slot_sig[pxbar_pkg::PXBAR_S_CEXB] = i_cex_b;
        slot_sig[pxbar_pkg::PXBAR_S_CEXC] = i_cex_c;
    end

    // =========================================================
    // per-pin output stage
    // =========================================================
    logic [NP-1:0] pin_rx;    // digital receiver gated value

    genvar p;
    generate
        for (p = 0; p < NP; p++)
        begin : g_pin
            logic src_out;   // value wanted on pin
            logic src_oe;    // source wants to drive
            logic od;        // open-drain in effect
            logic drv_low;   // actively pulling low
            logic drv_high;  // actively pushing high
            logic open_drn;  // two-wire bus pin
            always_comb
            begin
                src_out = i_port_cfg.latch[p];
                src_oe  = 1'b1;
                open_drn = 1'b0;
                // uart tx is driven, rx pin is input only
                if (uart_on && PW'(p) == uart_tx_pin)
                begin
                    src_out   = i_uart_tx.out;
                    src_oe    = i_uart_tx.oe;
                end
                else if (uart_on && PW'(p) == uart_rx_pin)
                begin
                    // released for the far end
                    src_out   = 1'b1;
                    src_oe    = 1'b0;
                end
                // slots never share a pin
                for (int k = 0; k < NS; k++)
                begin
                    if (placed[k] && slot_pin[k*PW +: PW] == PW'(p))
                    begin
                        src_out   = slot_sig[k].out;
                        src_oe    = slot_sig[k].oe;
                        if (k == pxbar_pkg::PXBAR_S_SDA || k == pxbar_pkg::PXBAR_S_SCL)
                        begin
                            open_drn = 1'b1;
                        end
                    end
                end
                // driver type from the mode bit alone, except two-wire bus pins
                od       = !i_port_cfg.pushpull[p] || open_drn;
                drv_low  = src_oe && !src_out;
                // open-drain with a one floats
                drv_high = src_oe && src_out && !od;
            end
            // drivers off while disabled or analog; analog ignores driver type
            assign o_pin_oe[p]  = router_enable && i_port_cfg.digital[p]
                               && (drv_low || drv_high);
            // high only when really pushed
            assign o_pin_out[p] = drv_high;
            // pullup only on open-drain digital pins not driving low
            assign o_pin_pullup[p] = !pullup_disable && i_port_cfg.digital[p] && od
                                  && !(router_enable && drv_low);
            // receiver follows the input kind
            assign o_pin_rx_en[p] = i_port_cfg.digital[p];
            // analog pins read zero, digital pins read the pad
            assign pin_rx[p] = i_port_cfg.digital[p] && i_pin_in[p];
        end
    endgenerate

    // reads the pad whatever the routing
    assign o_port_read = pin_rx;

    // =========================================================
    // peripheral input return path
    // =========================================================
    // an unrouted input idles high so no false edges reach the peripheral
    // a process, so every pin and slot change wakes it
    logic [NS-1:0] slot_rx;  // pad value seen by each slot

    always_comb
    begin
        for (int k = 0; k < NS; k++)
        begin
            slot_rx[k] = 1'b1;
            if (router_enable && placed[k])
            begin
                slot_rx[k] = pin_rx[slot_pin[k*PW +: PW]];
            end
        end
    end

    // uart rx has a fixed pin, the rest their slot
    assign o_uart_receive_line      = (router_enable && uart_on) ? pin_rx[uart_rx_pin] : 1'b1;
    assign o_spi_sck_in             = slot_rx[pxbar_pkg::PXBAR_S_SCK];
    assign o_spi_miso_in            = slot_rx[pxbar_pkg::PXBAR_S_MISO];
    assign o_spi_mosi_in            = slot_rx[pxbar_pkg::PXBAR_S_MOSI];
    assign o_spi_nss_in             = slot_rx[pxbar_pkg::PXBAR_S_NSS];
    assign o_smb_sda_in             = slot_rx[pxbar_pkg::PXBAR_S_SDA];
    assign o_smb_scl_in             = slot_rx[pxbar_pkg::PXBAR_S_SCL];
    assign o_capture_a_in           = slot_rx[pxbar_pkg::PXBAR_S_CEXA];
    assign o_capture_b_in           = slot_rx[pxbar_pkg::PXBAR_S_CEXB];
    assign o_capture_c_in           = slot_rx[pxbar_pkg::PXBAR_S_CEXC];
    assign o_counter_array_clock_in = slot_rx[pxbar_pkg::PXBAR_S_ECI];
    assign o_timer_a_in             = slot_rx[pxbar_pkg::PXBAR_S_TMRA];
    assign o_timer_b_in             = slot_rx[pxbar_pkg::PXBAR_S_TMRB];

endmodule

// File: sim/pxbar_assertions.sv
// checker: concurrent properties on the crossbar ports
`timescale 1ns/1ps
module pxbar_checker (
    input wire logic                      i_clk_sys,
    input wire logic                      i_sys_rst,
    input wire logic [7:0]                i_sfr_addr,
    input wire logic [7:0]                i_sfr_wdata,
    input wire logic                      i_sfr_wr,
    input wire logic                      i_sfr_rd,
    input wire logic [7:0]                o_sfr_rdata,
    input wire logic                      o_sfr_hit,
    input wire pxbar_pkg::pxbar_portcfg_t i_port_cfg,
    input wire logic [15:0]               o_pin_out,
    input wire logic [15:0]               o_pin_oe,
    input wire logic [15:0]               o_pin_pullup,
    input wire logic [15:0]               o_pin_rx_en
);
    logic [7:0] ctrl_q; // mirror of control register b, reserved bit dropped
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            ctrl_q <= 8'h00;
        else if (i_sfr_wr && i_sfr_addr == 8'he2)
            ctrl_q <= i_sfr_wdata & 8'hfb;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    sequence s_read_b;
        i_sfr_rd && !i_sfr_wr && i_sfr_addr == 8'he2;
    endsequence
    a_ctrl_read_back: assert property (s_read_b |=> o_sfr_rdata == ctrl_q)
        else $error("control readback wrong");
    a_unmapped_zero: assert property (i_sfr_rd && !o_sfr_hit |=> o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_route_top_zero: assert property (i_sfr_rd && i_sfr_addr == 8'he1 |=> !o_sfr_rdata[7:6])
        else $error("route reserved bits set");
    a_drivers_off: assert property (!ctrl_q[6] |-> o_pin_oe == 16'h0000)
        else $error("driver on while disabled");
    a_pullup_off: assert property (ctrl_q[7] |-> o_pin_pullup == 16'h0000)
        else $error("pullup on while disabled");
    a_analog_quiet: assert property (!((o_pin_oe | o_pin_pullup | o_pin_rx_en) & ~i_port_cfg.digital))
        else $error("analog pin not quiet");
    a_rx_kind: assert property (o_pin_rx_en == i_port_cfg.digital)
        else $error("receiver enable wrong");
    a_low_no_pull: assert property (!(o_pin_pullup & o_pin_oe & ~o_pin_out))
        else $error("pullup on low driver");
endmodule
bind pxbar_top pxbar_checker pxbar_checker_i (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .i_port_cfg(i_port_cfg),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pin_pullup(o_pin_pullup),
    .o_pin_rx_en(o_pin_rx_en));

// File: sim/pxbar_pad_model.sv
// pad model: resolves each pin level from drivers, pullups and the outside world
`timescale 1ns/1ps
module pxbar_pad_model (
    input  wire logic [15:0] i_out,
    input  wire logic [15:0] i_oe,
    input  wire logic [15:0] i_pullup,
    input  wire logic [15:0] i_ext,
    output logic      [15:0] o_pin
);
    // released pins follow the pullup, else the outside level
    assign o_pin = i_oe & i_out | ~i_oe & (i_pullup | i_ext);
endmodule

// File: sim/pxbar_top_tb_top.sv
// testbench: register and pin scenarios for the pin crossbar
`timescale 1ns/1ps
module pxbar_top_tb_top;
    logic                      clk = 1'b0;
    logic                      rst = 1'b1;
    logic                      wr = 1'b0;
    logic                      rd = 1'b0;
    logic [7:0]                addr = 8'h00;
    logic [7:0]                wd = 8'h00;
    logic [7:0]                rdata;
    logic [1:0]                nss = 2'h2;
    pxbar_pkg::pxbar_portcfg_t cfg = '0;
    pxbar_pkg::pxbar_sig_t     pd = '0;
    logic [15:0]               pin, pout, poe, ppu, prx, prd;
    logic                      urx, tbi;
    int                        err_total = 0;
    int                        cmp_count = 0;
    int                        cyc = 0;
    always #5 clk = ~clk;
    pxbar_top pxbar_top_i (.i_clk_sys(clk), .i_sys_rst(rst), .i_sfr_addr(addr), .i_sfr_wdata(wd),
        .i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata), .o_sfr_hit(), .i_port_cfg(cfg),
        .i_spi_select_mode_field(nss), .i_uart_tx(pd), .i_spi_sck(pd), .i_spi_miso(pd),
        .i_spi_mosi(pd), .i_spi_nss(pd), .i_smb_sda(pd), .i_smb_scl(pd), .i_cex_a(pd),
        .i_comparator_output(pd.out), .i_comparator_output_async(pd.out), .i_sysclk_inv(pd.out),
        .i_cex_b(pd), .i_cex_c(pd), .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe(poe),
        .o_pin_pullup(ppu), .o_pin_rx_en(prx), .o_port_read(prd), .o_uart_receive_line(urx),
        .o_spi_sck_in(), .o_spi_miso_in(), .o_spi_mosi_in(), .o_spi_nss_in(), .o_smb_sda_in(),
        .o_smb_scl_in(), .o_capture_a_in(), .o_capture_b_in(), .o_capture_c_in(),
        .o_counter_array_clock_in(), .o_timer_a_in(), .o_timer_b_in(tbi));
    pxbar_pad_model pxbar_pad_model_i (.i_out(pout), .i_oe(poe), .i_pullup(ppu),
        .i_ext(16'h3c5a), .o_pin(pin));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask
    // port mode inputs: latch, input kind, driver type, skip
    task automatic setp(input logic [15:0] l, input logic [15:0] d, input logic [15:0] p,
        input logic [15:0] s);
        @(posedge clk);
        cfg <= {l, d, p, s};
        #1;
    endtask
    task automatic complete_run;
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // hang guard, far above the roughly 54 cycles the sequence needs
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total++;
            complete_run();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        setp(16'hffff, 16'hffff, 16'h0000, 16'h0000);
        rreg(8'he1, 8'h00);
        chk(poe, 16'h0000);
        chk(ppu, 16'hffff);
        chk(prd, 16'hffff);
        wreg(8'he1, 8'hff);
        rreg(8'he1, 8'h3f);
        wreg(8'he9, 8'hff);
        rreg(8'he9, 8'h00);
        wreg(8'he2, 8'hff);
        rreg(8'he2, 8'hfb);
        wreg(8'he1, 8'h00);
        wreg(8'he2, 8'h80);
        chk(prd, 16'h3c5a);
        setp(16'hffff, 16'hffff, 16'h00ff, 16'h0000);
        wreg(8'he2, 8'h40);
        chk(poe, 16'h00ff);
        chk(ppu, 16'hff00);
        setp(16'h0000, 16'hfff0, 16'h00ff, 16'h000f);
        chk(poe, 16'hfff0);
        chk(prx, 16'hfff0);
        @(posedge clk);
        pd <= 2'h3;
        setp(16'h0000, 16'hffff, 16'hffff, 16'h0030);
        wreg(8'he1, 8'h03);
        chk(pout, 16'h001f);
        chk(urx, 1'b0);
        @(posedge clk);
        nss <= 2'h0;
        setp(16'h0000, 16'hffff, 16'hffff, 16'h0031);
        chk(pout, 16'h001e);
        wreg(8'he1, 8'h04);
        chk(poe, 16'hfff9);
        for (int b = 3; b < 6; b++)
        begin
            wreg(8'he1, 8'h01 << b);
            chk(pout, 16'h0002);
        end
        wreg(8'he1, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            wreg(8'he2, 8'h40 | 8'(k));
            chk(pout, ((16'h0001 << k) - 16'h0001) << 1);
        end
        wreg(8'he2, 8'h70);
        chk(tbi, 1'b0);
        wreg(8'he2, 8'h00);
        chk(poe, 16'h0000);
        chk(tbi, 1'b1);
        complete_run();
    end
endmodule
